// ==== ced_pkg.sv ====
/*
 * Shared constants of the exception detection unit: cause codes,
 * register offsets, reset values and instruction field codes.
 * Assumes byte-addressed APB offsets, one 32-bit word per register.
 */
package ced_pkg;
	// ---------------------------------------------------------------
	// Cause codes
	// ---------------------------------------------------------------
	localparam logic [4:0] EXC_INT      = 5'h00;
	localparam logic [4:0] EXC_MOD      = 5'h01;
	localparam logic [4:0] EXC_MISS_LD  = 5'h02;
	localparam logic [4:0] EXC_MISS_ST  = 5'h03;
	localparam logic [4:0] EXC_ADE_LD   = 5'h04;
	localparam logic [4:0] EXC_ADE_ST   = 5'h05;
	localparam logic [4:0] EXC_FETCH_BE = 5'h06;
	localparam logic [4:0] EXC_DATA_BE  = 5'h07;
	localparam logic [4:0] EXC_SYSCALL  = 5'h08;
	localparam logic [4:0] EXC_BREAK    = 5'h09;
	localparam logic [4:0] EXC_RESV     = 5'h0A;
	localparam logic [4:0] EXC_COP      = 5'h0B;
	localparam logic [4:0] EXC_OVF      = 5'h0C;

	// ---------------------------------------------------------------
	// Vectors and offsets
	// ---------------------------------------------------------------
	localparam logic [31:0] RESET_VECTOR = 32'hBFC0_0000;
	localparam logic [31:0] DELAY_BACK   = 32'h0000_0004;
	localparam logic [7:0]  REG_STATUS   = 8'h00;
	localparam logic [7:0]  REG_CAUSE    = 8'h04;
	localparam logic [7:0]  REG_RESUME   = 8'h08;
	localparam logic [7:0]  REG_BADADDR  = 8'h0C;

	// ---------------------------------------------------------------
	// Reset values
	// ---------------------------------------------------------------
	localparam logic [5:0] STACK_RST = 6'h00;
	localparam logic [7:0] IM_RST    = 8'h00;
	localparam logic [3:0] CU_RST    = 4'h0;
	localparam logic [1:0] SW_RST    = 2'h0;

	// ---------------------------------------------------------------
	// Instruction fields and access sizes
	// ---------------------------------------------------------------
	localparam logic [5:0] OP_SPECIAL = 6'h00;
	localparam logic [3:0] OP_COP_HI  = 4'h4;
	localparam logic [5:0] FN_SYSCALL = 6'h0C;
	localparam logic [5:0] FN_BREAK   = 6'h0D;
	localparam logic [1:0] SIZE_HALF  = 2'h1;
	localparam logic [1:0] SIZE_WORD  = 2'h2;
endpackage

// ==== ced_sync.sv ====
/*
 * Two-flop synchroniser for pin levels.
 * Assumes the input is a level held for at least two clocks.
 */
`timescale 1ns/1ps
module ced_sync #(
	parameter int W = 1
) (
	input  wire logic         clk_sys,
	input  wire logic         rst_n,
	input  wire logic [W-1:0] din,
	output logic      [W-1:0] out_ff
);
	logic [W-1:0] meta_ff;

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			meta_ff <= '0;
			out_ff  <= '0;
		end else begin
			meta_ff <= din;
			out_ff  <= meta_ff;
		end
	end
endmodule // ced_sync

// ==== ced_classify.sv ====
/*
 * Exception classifier for one pipeline stage: finds every condition
 * of one instruction and reports the highest by fixed priority.
 * Assumes translation results and ALU flags belong to this instruction.
 */
`timescale 1ns/1ps
module ced_classify #(
	parameter logic        EXTENDED = 1'b1,
	parameter logic [63:0] MAJOR_OK = 64'h00FF_FFFF_FFFF_FFFF,
	parameter logic [63:0] MINOR_OK = 64'h0000_FFFF_FFFF_FFFF
) (
	input  wire logic        valid,
	input  wire logic        userMode,
	input  wire logic [31:0] pc,
	input  wire logic [31:0] instr,
	input  wire logic [3:0]  cuBits,
	input  wire logic        aluOvf,
	input  wire logic        aluTrap,
	input  wire logic        memRead,
	input  wire logic        memWrite,
	input  wire logic [1:0]  memSize,
	input  wire logic [31:0] dataAddr,
	input  wire logic        xlatHit,
	input  wire logic        xlatValid,
	input  wire logic        xlatDirty,
	input  wire logic        fetchBusErr,
	input  wire logic        dataBusErr,
	output logic             hit,
	output logic [4:0]       code,
	output logic             userMiss,
	output logic [1:0]       copNum,
	output logic [31:0]      badAddr
);
	// ---------------------------------------------------------------
	// Conditions
	// ---------------------------------------------------------------
	wire [5:0] major = instr[31:26];
	wire [5:0] minor = instr[5:0];
	wire isSpecial = major == ced_pkg::OP_SPECIAL;
	wire isCop = major[5:2] == ced_pkg::OP_COP_HI;
	wire fetchAdErr = (pc[1:0] != 2'h0) | (userMode & pc[31]); // RQ6 RQ7
	wire resvOp = ~MAJOR_OK[major] | (isSpecial & ~MINOR_OK[minor]); // RQ11
	wire copUnusable = isCop & ~cuBits[major[1:0]]; // RQ12
	wire sysTrap = isSpecial & (minor == ced_pkg::FN_SYSCALL); // RQ9
	wire brkTrap = isSpecial & (minor == ced_pkg::FN_BREAK); // RQ10
	wire ovfTrap = aluTrap & aluOvf; // RQ8
	wire memRef = memRead | memWrite;
	wire misalign = ((memSize == ced_pkg::SIZE_WORD) & (dataAddr[1:0] != 2'h0))
		| ((memSize == ced_pkg::SIZE_HALF) & dataAddr[0]);
	wire dataAdErr = memRef & (misalign | (userMode & dataAddr[31])); // RQ6 RQ7
	wire userSeg = ~dataAddr[31];
	wire kMapSeg = dataAddr[31:30] == 2'h3;
	// Faulting addresses never reach translation
	wire xlatRef = EXTENDED & memRef & ~dataAdErr & (userSeg | kMapSeg);
	wire userXlatMiss = xlatRef & ~xlatHit & userSeg; // RQ2
	wire xlatMiss = xlatRef & ((~xlatHit & kMapSeg) | (xlatHit & ~xlatValid)); // RQ3
	wire xlatMod = xlatRef & memWrite & xlatHit & xlatValid & ~xlatDirty; // RQ4
	wire dataBe = memRead & dataBusErr; // RQ5
	wire [4:0] missCode = memWrite ? ced_pkg::EXC_MISS_ST : ced_pkg::EXC_MISS_LD;
	wire [4:0] adeCode = memWrite ? ced_pkg::EXC_ADE_ST : ced_pkg::EXC_ADE_LD;

	// ---------------------------------------------------------------
	// Fixed priority
	// ---------------------------------------------------------------
	assign hit = valid & (fetchAdErr | fetchBusErr | resvOp | copUnusable
		| sysTrap | brkTrap | ovfTrap | dataAdErr | userXlatMiss
		| xlatMiss | xlatMod | dataBe);
	assign code = fetchAdErr ? ced_pkg::EXC_ADE_LD : // RQ22
		fetchBusErr ? ced_pkg::EXC_FETCH_BE :
		resvOp ? ced_pkg::EXC_RESV :
		copUnusable ? ced_pkg::EXC_COP :
		sysTrap ? ced_pkg::EXC_SYSCALL :
		brkTrap ? ced_pkg::EXC_BREAK :
		ovfTrap ? ced_pkg::EXC_OVF :
		dataAdErr ? adeCode :
		(userXlatMiss | xlatMiss) ? missCode :
		xlatMod ? ced_pkg::EXC_MOD : ced_pkg::EXC_DATA_BE;
	assign userMiss = userXlatMiss & ~(fetchAdErr | fetchBusErr | resvOp
		| copUnusable | sysTrap | brkTrap | ovfTrap);
	assign copNum = major[1:0];
	assign badAddr = fetchAdErr ? pc : dataAddr;
endmodule // ced_classify

// ==== ced_top.sv ====
/*
 * Exception detection and dispatch unit with APB register access.
 * Assumes the pipeline holds the two oldest stages steady and obeys
 * the registered abort and redirect outputs one cycle after detection.
 */
// Function
// RQ1: Reset forces a jump to the fixed reset vector.
// RQ2: Extended core: unmapped user-segment access raises user miss.
// RQ3: Extended core: invalid entry or unmapped kernel page raises miss.
// RQ4: Extended core: store to valid but clean entry raises modified.
// RQ5: Bus error pin during a read raises fetch or data bus error.
// RQ6: Misaligned word or halfword access raises load or store address error.
// RQ7: User-mode reference with address top bit set raises address error.
// RQ8: Trapping add or subtract with overflow raises overflow.
// RQ9: System call instruction raises system call exception.
// RQ10: Break instruction raises breakpoint exception.
// RQ11: Undefined major or special minor opcode raises reserved opcode.
// RQ12: Coprocessor instruction with usable bit clear raises unusable.
// RQ13: Enabled hardware or software interrupt raises interrupt exception.
// RQ14: Any exception suspends flow and enters kernel mode.
// RQ15: Excepting and all younger instructions are aborted.
// RQ16: Exceptions are precise; nothing later changes machine state.
// RQ17: After aborting, control jumps straight to the handler.
// RQ18: Cause of latest exception kept as five-bit code.
// RQ19: Resume address saved; delay slot saves branch address and flag.
// RQ20: Exception pushes mode and enable stack; restore pops it.
// RQ21: Coprocessor unusable captures referenced coprocessor number.
// RQ22: Simultaneous conditions report the oldest instruction, fixed priority.
`timescale 1ns/1ps
module ced_top #(
	parameter int          ADDR_W      = 8,
	parameter logic        EXTENDED    = 1'b1,
	parameter logic [31:0] GEN_VECTOR  = 32'h8000_0080,
	parameter logic [31:0] UTLB_VECTOR = 32'h8000_0000,
	parameter logic [63:0] MAJOR_OK    = 64'h00FF_FFFF_FFFF_FFFF,
	parameter logic [63:0] MINOR_OK    = 64'h0000_FFFF_FFFF_FFFF
) (
	input  wire logic              clk_sys,
	input  wire logic              rst_n,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [ADDR_W-1:0] paddr,
	input  wire logic [31:0]       pwdata,
	output logic      [31:0]       prdata_ff,
	output logic                   pready_ff,
	output logic                   pslverr_ff,
	input  wire logic              busErrorPin,
	input  wire logic [5:0]        hwIrqPin,
	input  wire logic              rfe,
	input  wire logic              oldValid,
	input  wire logic [31:0]       oldPc,
	input  wire logic              oldInDelay,
	input  wire logic [31:0]       oldInstr,
	input  wire logic              oldAluOvf,
	input  wire logic              oldAluTrap,
	input  wire logic              oldMemRead,
	input  wire logic              oldMemWrite,
	input  wire logic [1:0]        oldMemSize,
	input  wire logic [31:0]       oldDataAddr,
	input  wire logic              oldXlatHit,
	input  wire logic              oldXlatValid,
	input  wire logic              oldXlatDirty,
	input  wire logic              yngValid,
	input  wire logic [31:0]       yngPc,
	input  wire logic              yngInDelay,
	input  wire logic [31:0]       yngInstr,
	input  wire logic              yngAluOvf,
	input  wire logic              yngAluTrap,
	output logic                   abortOld_ff,
	output logic                   abortYoung_ff,
	output logic                   redirect_ff,
	output logic      [31:0]       redirectPc_ff,
	output logic                   kernelMode_ff
);
	logic [5:0]  stack_ff;
	logic [7:0]  im_ff;
	logic [3:0]  cu_ff;
	logic [1:0]  sw_ff;
	logic [4:0]  code_ff;
	logic        bd_ff;
	logic [1:0]  ce_ff;
	logic [31:0] resume_ff;
	logic [31:0] badAddr_ff;
	logic        resetPending_ff;
	logic        busErrSync;
	logic [5:0]  hwIrqSync;
	logic        oldHit, yngHit, oldUserMiss;
	logic [4:0]  oldCode, yngCode;
	logic [1:0]  oldCe, yngCe;
	logic [31:0] oldBad, yngBad;

	// ---------------------------------------------------------------
	// Pin synchronisers
	// ---------------------------------------------------------------
	ced_sync #(.W(1)) uBusErr (
		.clk_sys (clk_sys),
		.rst_n   (rst_n),
		.din     (busErrorPin),
		.out_ff  (busErrSync)
	);
	ced_sync #(.W(6)) uIrq (
		.clk_sys (clk_sys),
		.rst_n   (rst_n),
		.din     (hwIrqPin),
		.out_ff  (hwIrqSync)
	);

	// ---------------------------------------------------------------
	// Per-stage classification
	// ---------------------------------------------------------------
	wire userMode = stack_ff[1];
	// A pending read in the older stage owns the bus error
	wire fetchBe = busErrSync & ~oldMemRead; // RQ5

	ced_classify #(.EXTENDED(EXTENDED), .MAJOR_OK(MAJOR_OK),
		.MINOR_OK(MINOR_OK)) uOld (
		.valid       (oldValid),
		.userMode    (userMode),
		.pc          (oldPc),
		.instr       (oldInstr),
		.cuBits      (cu_ff),
		.aluOvf      (oldAluOvf),
		.aluTrap     (oldAluTrap),
		.memRead     (oldMemRead),
		.memWrite    (oldMemWrite),
		.memSize     (oldMemSize),
		.dataAddr    (oldDataAddr),
		.xlatHit     (oldXlatHit),
		.xlatValid   (oldXlatValid),
		.xlatDirty   (oldXlatDirty),
		.fetchBusErr (1'b0),
		.dataBusErr  (busErrSync),
		.hit         (oldHit),
		.code        (oldCode),
		.userMiss    (oldUserMiss),
		.copNum      (oldCe),
		.badAddr     (oldBad)
	);
	ced_classify #(.EXTENDED(EXTENDED), .MAJOR_OK(MAJOR_OK),
		.MINOR_OK(MINOR_OK)) uYng (
		.valid       (yngValid),
		.userMode    (userMode),
		.pc          (yngPc),
		.instr       (yngInstr),
		.cuBits      (cu_ff),
		.aluOvf      (yngAluOvf),
		.aluTrap     (yngAluTrap),
		.memRead     (1'b0),
		.memWrite    (1'b0),
		.memSize     (2'h0),
		.dataAddr    (32'h0000_0000),
		.xlatHit     (1'b0),
		.xlatValid   (1'b0),
		.xlatDirty   (1'b0),
		.fetchBusErr (fetchBe),
		.dataBusErr  (1'b0),
		.hit         (yngHit),
		.code        (yngCode),
		.userMiss    (),
		.copNum      (yngCe),
		.badAddr     (yngBad)
	);

	// ---------------------------------------------------------------
	// Selection, oldest first
	// ---------------------------------------------------------------
	// Stale stage contents are ignored while the redirect is in flight
	wire busy = redirect_ff | resetPending_ff; // RQ16
	wire [7:0] irqPend = {hwIrqSync, sw_ff} & im_ff;
	wire intReq = (|irqPend) & stack_ff[0] & oldValid; // RQ13
	wire takeOld = ~busy & oldHit; // RQ22
	wire takeInt = ~busy & ~oldHit & intReq; // RQ13
	wire takeYng = ~busy & ~oldHit & ~intReq & yngHit; // RQ22
	wire take = takeOld | takeInt | takeYng;
	wire [4:0] selCode = takeOld ? oldCode :
		takeInt ? ced_pkg::EXC_INT : yngCode;
	wire [31:0] selPc = takeYng ? yngPc : oldPc;
	wire selDelay = takeYng ? yngInDelay : oldInDelay;
	wire [1:0] selCe = takeYng ? yngCe : oldCe;
	wire [31:0] selBad = takeYng ? yngBad : oldBad;
	wire [31:0] resumePc = selDelay ? selPc - ced_pkg::DELAY_BACK : selPc; // RQ19
	wire selUtlb = takeOld & oldUserMiss;
	wire [31:0] vector = selUtlb ? UTLB_VECTOR : GEN_VECTOR; // RQ17
	wire addrExc = (selCode == ced_pkg::EXC_ADE_LD)
		| (selCode == ced_pkg::EXC_ADE_ST)
		| (selCode == ced_pkg::EXC_MISS_LD)
		| (selCode == ced_pkg::EXC_MISS_ST)
		| (selCode == ced_pkg::EXC_MOD);

	// ---------------------------------------------------------------
	// APB decode
	// ---------------------------------------------------------------
	wire apbAcc = psel & penable & ~pready_ff;
	wire wrEn = psel & penable & pready_ff & pwrite;
	wire selStatus = paddr == ADDR_W'(ced_pkg::REG_STATUS);
	wire selCause = paddr == ADDR_W'(ced_pkg::REG_CAUSE);
	wire selResume = paddr == ADDR_W'(ced_pkg::REG_RESUME);
	wire selBadAddr = paddr == ADDR_W'(ced_pkg::REG_BADADDR);
	wire mapped = selStatus | selCause | selResume | selBadAddr;
	wire [31:0] statusWord = {cu_ff, 12'h000, im_ff, 2'h0, stack_ff};
	wire [31:0] causeWord = {bd_ff, 1'b0, ce_ff, 12'h000, hwIrqSync, sw_ff,
		1'b0, code_ff, 2'h0};
	wire [31:0] rdMux = selStatus ? statusWord :
		selCause ? causeWord :
		selResume ? resume_ff :
		selBadAddr ? badAddr_ff : 32'h0000_0000;

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			pready_ff  <= 1'b0;
			pslverr_ff <= 1'b0;
			prdata_ff  <= 32'h0000_0000;
		end else begin
			pready_ff  <= apbAcc;
			pslverr_ff <= apbAcc & ~mapped;
			prdata_ff  <= (apbAcc & ~pwrite) ? rdMux : 32'h0000_0000;
		end
	end

	// ---------------------------------------------------------------
	// Mode and enable stack
	// ---------------------------------------------------------------
	wire [5:0] pushedStack = {stack_ff[3:0], 2'h0};
	wire [5:0] poppedStack = {stack_ff[5:4], stack_ff[5:2]};
	wire wrStatus = wrEn & selStatus;
	// Hardware push beats restore and software writes
	wire [5:0] nxt_stack = take ? pushedStack : // RQ14 RQ20
		rfe ? poppedStack : // RQ20
		wrStatus ? pwdata[5:0] : stack_ff;

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			stack_ff      <= ced_pkg::STACK_RST;
			im_ff         <= ced_pkg::IM_RST;
			cu_ff         <= ced_pkg::CU_RST;
			kernelMode_ff <= 1'b1;
		end else begin
			stack_ff      <= nxt_stack;
			kernelMode_ff <= ~nxt_stack[1]; // RQ14
			if (wrStatus) begin
				im_ff <= pwdata[15:8];
				cu_ff <= pwdata[31:28];
			end
		end
	end

	// ---------------------------------------------------------------
	// Cause, resume and bad address capture
	// ---------------------------------------------------------------
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			code_ff    <= ced_pkg::EXC_INT;
			bd_ff      <= 1'b0;
			ce_ff      <= 2'h0;
			sw_ff      <= ced_pkg::SW_RST;
			resume_ff  <= 32'h0000_0000;
			badAddr_ff <= 32'h0000_0000;
		end else begin
			if (take) begin
				code_ff   <= selCode; // RQ18
				bd_ff     <= selDelay; // RQ19
				resume_ff <= resumePc; // RQ19
			end
			if (take & (selCode == ced_pkg::EXC_COP))
				ce_ff <= selCe; // RQ21
			if (take & addrExc)
				badAddr_ff <= selBad;
			if (wrEn & selCause)
				sw_ff <= pwdata[9:8];
		end
	end

	// ---------------------------------------------------------------
	// Abort and redirect
	// ---------------------------------------------------------------
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			resetPending_ff <= 1'b1;
			redirect_ff     <= 1'b0;
			redirectPc_ff   <= 32'h0000_0000;
			abortOld_ff     <= 1'b0;
			abortYoung_ff   <= 1'b0;
		end else begin
			resetPending_ff <= 1'b0;
			redirect_ff     <= resetPending_ff | take; // RQ1 RQ17
			redirectPc_ff   <= resetPending_ff ? ced_pkg::RESET_VECTOR : vector; // RQ1
			abortOld_ff     <= resetPending_ff | takeOld | takeInt; // RQ15
			abortYoung_ff   <= resetPending_ff | take; // RQ15
		end
	end

	// ---------------------------------------------------------------
	// Assertions
	// ---------------------------------------------------------------
	a_reset_jump: assert property ( // RQ1
		@(posedge clk_sys) disable iff (!rst_n)
		(rst_n && !$past(rst_n)) |=>
			(redirect_ff && redirectPc_ff == ced_pkg::RESET_VECTOR))
		else $error("reset vector not taken");
	a_oldest_wins: assert property ( // RQ22
		@(posedge clk_sys) disable iff (!rst_n)
		(!busy && oldHit && yngHit) |=>
			(code_ff == $past(oldCode) && abortOld_ff))
		else $error("younger exception beat older");
	a_kernel_entry: assert property ( // RQ14
		@(posedge clk_sys) disable iff (!rst_n)
		take |=> kernelMode_ff && !stack_ff[1])
		else $error("kernel mode not entered");
	a_abort_young: assert property ( // RQ15
		@(posedge clk_sys) disable iff (!rst_n)
		take |=> abortYoung_ff ##1 !abortYoung_ff)
		else $error("younger work not aborted once");
	a_no_double: assert property ( // RQ16
		@(posedge clk_sys) disable iff (!rst_n)
		redirect_ff |=> !redirect_ff && $stable(code_ff) && $stable(resume_ff))
		else $error("state changed during redirect");
	a_handler_jump: assert property ( // RQ17
		@(posedge clk_sys) disable iff (!rst_n)
		take |=> (redirect_ff && redirectPc_ff ==
			($past(selUtlb) ? UTLB_VECTOR : GEN_VECTOR)))
		else $error("handler address wrong");
	a_slot_resume: assert property ( // RQ19
		@(posedge clk_sys) disable iff (!rst_n)
		(take && selDelay) |=>
			(bd_ff && resume_ff == $past(selPc) - ced_pkg::DELAY_BACK))
		else $error("delay slot resume wrong");
	a_stack_push: assert property ( // RQ20
		@(posedge clk_sys) disable iff (!rst_n)
		take |=> stack_ff == {$past(stack_ff[3:0]), 2'h0})
		else $error("mode stack not pushed");
	a_stack_pop: assert property ( // RQ20
		@(posedge clk_sys) disable iff (!rst_n)
		(rfe && !take) |=>
			stack_ff == {$past(stack_ff[5:4]), $past(stack_ff[5:2])})
		else $error("mode stack not popped");
	a_cop_number: assert property ( // RQ21
		@(posedge clk_sys) disable iff (!rst_n)
		(take && selCode == ced_pkg::EXC_COP) |=> ce_ff == $past(selCe))
		else $error("coprocessor number lost");
	a_irq_taken: assert property ( // RQ13
		@(posedge clk_sys) disable iff (!rst_n)
		(!busy && !oldHit && intReq) |=>
			(code_ff == ced_pkg::EXC_INT && redirect_ff))
		else $error("interrupt not taken");
	a_apb_wait: assert property (
		@(posedge clk_sys) disable iff (!rst_n)
		(psel && penable && !pready_ff) |=> pready_ff)
		else $error("apb answer late");
endmodule // ced_top

// ==== ced_ext_model.sv ====
/*
 * Far-side model: interrupt sources and the memory bus error line.
 * Assumes the bench requests pin levels just after a rising clock edge.
 */
`timescale 1ns/1ps
module ced_ext_model (
	input  wire logic       clk_sys,
	input  wire logic       rst_n,
	input  wire logic [5:0] irqSet,
	input  wire logic       busErrSet,
	output logic      [5:0] hwIrqPin_ff,
	output logic            busErrorPin_ff
);
	// ---------------------------------------------------------------
	// Pin drivers
	// ---------------------------------------------------------------
	// Levels held until withdrawn, long enough for the synchroniser
	always_ff @(posedge clk_sys) begin
		hwIrqPin_ff    <= rst_n ? irqSet : 6'h00;
		busErrorPin_ff <= rst_n && busErrSet;
	end
endmodule // ced_ext_model

// ==== test_cpu_exception_detection_unit.sv ====
/*
 * Self-checking bench of the exception unit: APB tasks, stage stimulus.
 * Assumes the default opcode tables and an extended core.
 */
`timescale 1ns/1ps
module test_cpu_exception_detection_unit;
	localparam logic [31:0] GV = 32'h8000_0080;
	localparam logic [31:0] UV = 32'h8000_0000;
	localparam logic [31:0] OA [7] = '{32'h102, 32'h101, 32'h104,
		32'h108, 32'h10C, 32'h110, 32'hC000_0000};
	localparam logic [4:0]  OC [7] = '{5'h04, 5'h05, 5'h01, 5'h02, 5'h07,
		5'h02, 5'h02};
	localparam logic [31:0] YI [7] = '{32'h0000_000C, 32'h0000_000D,
		32'hE000_0000, 32'h0000_0030, 32'h4400_0000, 32'h0000_0020,
		32'h0000_0000};
	localparam logic [4:0]  YC [7] = '{5'h08, 5'h09, 5'h0A, 5'h0A, 5'h0B,
		5'h0C, 5'h06};
	logic        clk_sys = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0;
	logic        pwrite = 1'b0, rfe = 1'b0, busErrSet = 1'b0, err;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, oldPc = 32'h0, oldDataAddr = 32'h0;
	logic [31:0] yngPc = 32'h0, yngInstr = 32'h0, oldInstr = 32'h0, rd;
	logic [31:0] prdata_ff, redirectPc_ff;
	logic        pready_ff, pslverr_ff, abortOld_ff, abortYoung_ff;
	logic        redirect_ff, kernelMode_ff, busErrorPin;
	logic [5:0]  irqSet = 6'h00, hwIrqPin;
	logic        oldValid = 1'b0, oldInDelay = 1'b0, oldMemRead = 1'b0;
	logic        oldMemWrite = 1'b0, oldAluOvf = 1'b0, oldAluTrap = 1'b0;
	logic        oldXlatHit = 1'b1, oldXlatValid = 1'b1, oldXlatDirty = 1'b1;
	logic        yngValid = 1'b0, yngInDelay = 1'b0, yngAluOvf = 1'b0;
	logic        yngAluTrap = 1'b0;
	logic [1:0]  oldMemSize = 2'h2;
	int          fails = 0, checked = 0;

	ced_top #(.GEN_VECTOR(GV), .UTLB_VECTOR(UV)) DUT (.*);
	ced_ext_model MDL (.clk_sys, .rst_n, .irqSet, .busErrSet,
		.hwIrqPin_ff(hwIrqPin), .busErrorPin_ff(busErrorPin));

	always #50 clk_sys = ~clk_sys;

	// ---------------------------------------------------------------
	// Tasks
	// ---------------------------------------------------------------
	task automatic tally_and_finish;
		$display("comparisons %0d mismatches %0d", checked, fails);
		if (fails == 0 && checked > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	task automatic chk(input string w, input logic [31:0] e,
		input logic [31:0] g);
		checked++;
		if (g !== e) begin
			fails++;
			$display("wrong value %s expected %h seen %h", w, e, g);
		end
	endtask

	// Entered and left just after a rising edge
	task automatic apb(input logic wr, input logic [7:0] a,
		input logic [31:0] d);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		do begin
			@(posedge clk_sys);
			n++;
		end while (pready_ff !== 1'b1 && n < 20);
		if (n >= 20) begin
			fails++;
			tally_and_finish();
		end
		rd = prdata_ff;
		err = pslverr_ff;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk_sys);
	endtask

	// Waits for the redirect, flushes the stages, reads back state
	task automatic takeExc(input logic [31:0] vec, input logic aOld,
		input logic [31:0] cause, input logic [31:0] mask,
		input logic [31:0] res);
		int n;
		n = 0;
		do begin
			@(posedge clk_sys);
			n++;
		end while (redirect_ff !== 1'b1 && n < 20);
		if (n >= 20) begin
			fails++;
			tally_and_finish();
		end
		chk("vector", vec, redirectPc_ff);
		chk("abort old", {31'h0, aOld}, {31'h0, abortOld_ff});
		chk("abort young", 32'h1, {31'h0, abortYoung_ff});
		chk("kernel", 32'h1, {31'h0, kernelMode_ff});
		oldValid <= 1'b0;
		yngValid <= 1'b0;
		irqSet <= 6'h00;
		busErrSet <= 1'b0;
		@(posedge clk_sys);
		if (mask != 32'h0) begin
			apb(1'b0, ced_pkg::REG_CAUSE, 32'h0);
			chk("cause", cause, rd & mask);
			apb(1'b0, ced_pkg::REG_RESUME, 32'h0);
			chk("resume", res, rd);
		end
	endtask

	// ---------------------------------------------------------------
	// Sequence
	// ---------------------------------------------------------------
	initial begin
		int i;
		repeat (2) @(posedge clk_sys);
		rst_n <= 1'b1;
		takeExc(ced_pkg::RESET_VECTOR, 1'b1, 0, 0, 0);
		// Older fault must win over the younger syscall behind it; the data bus error case has no younger instruction
		for (i = 0; i < 7; i++) begin
			oldValid <= 1'b1;
			oldPc <= 32'h100 + i * 8;
			oldMemRead <= (i == 0 || i >= 3);
			oldMemWrite <= (i == 1 || i == 2);
			oldMemSize <= (i == 1) ? ced_pkg::SIZE_HALF : ced_pkg::SIZE_WORD;
			oldDataAddr <= OA[i];
			oldXlatValid <= (i != 3);
			oldXlatDirty <= (i != 2);
			oldXlatHit <= (i < 5);
			busErrSet <= (i == 4);
			yngValid <= (i != 4);
			yngInstr <= YI[0];
			takeExc((i == 5) ? UV : GV, 1'b1, {25'h0, OC[i], 2'h0}, 32'h7C,
				32'h100 + i * 8);
		end
		// Younger bus error needs no data read pending in the older stage
		oldMemRead <= 1'b0;
		for (i = 0; i < 7; i++) begin
			busErrSet <= (i == 6);
			yngValid <= 1'b1;
			yngPc <= 32'h304 + i * 8;
			yngInDelay <= (i == 0);
			yngInstr <= YI[i];
			yngAluTrap <= (i == 5);
			yngAluOvf <= (i == 5);
			takeExc(GV, 1'b0, {i == 0, 1'b0, (i == 4) ? 2'h1 : 2'h0, 21'h0,
				YC[i], 2'h0}, (i == 4) ? 32'hB000_007C : 32'h8000_007C,
				(i == 0) ? 32'h300 : 32'h304 + i * 8);
		end
		apb(1'b1, ced_pkg::REG_STATUS, 32'h0000_0401);
		irqSet <= 6'h01;
		oldValid <= 1'b1;
		oldPc <= 32'h400;
		oldMemRead <= 1'b0;
		oldMemWrite <= 1'b0;
		takeExc(GV, 1'b1, 32'h0, 32'h7C, 32'h400);
		apb(1'b1, ced_pkg::REG_STATUS, 32'h0000_0002);
		@(posedge clk_sys);
		chk("user mode", 32'h0, {31'h0, kernelMode_ff});
		oldValid <= 1'b1;
		oldPc <= 32'h500;
		oldMemRead <= 1'b1;
		oldDataAddr <= 32'h8000_0000;
		takeExc(GV, 1'b1, 32'h10, 32'h7C, 32'h500);
		apb(1'b0, ced_pkg::REG_STATUS, 32'h0);
		chk("stack push", 32'h08, rd & 32'h3F);
		rfe <= 1'b1;
		@(posedge clk_sys);
		rfe <= 1'b0;
		apb(1'b0, ced_pkg::REG_STATUS, 32'h0);
		chk("stack pop", 32'h02, rd & 32'h3F);
		apb(1'b1, ced_pkg::REG_RESUME, 32'hFFFF_FFFF);
		apb(1'b0, ced_pkg::REG_RESUME, 32'h0);
		chk("resume read only", 32'h500, rd);
		apb(1'b0, 8'h10, 32'h0);
		chk("unmapped error", 32'h1, {31'h0, err});
		chk("unmapped data", 32'h0, rd);
		tally_and_finish();
	end
endmodule // test_cpu_exception_detection_unit
